// >>> rtl/exposure_trigger_pkg.sv
package exposure_trigger_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ctrl_addr      = 8'h00;
  localparam logic [7:0] frames_addr    = 8'h04;
  localparam logic [7:0] exposure_addr  = 8'h08;
  localparam logic [7:0] interval_addr  = 8'h0C;
  localparam logic [7:0] readout_addr   = 8'h10;
  localparam logic [7:0] command_addr   = 8'h14;
  localparam logic [7:0] status_addr    = 8'h18;
  localparam logic [7:0] done_addr      = 8'h1C;

  // ---------------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------------
  localparam int          source_lsb       = 0;
  localparam int          polarity_bit     = 2;
  localparam int          cmd_capture_bit  = 0;
  localparam int          cmd_halt_bit     = 1;
  localparam int          source_width     = 2;
  localparam int          frames_msb       = 15;
  localparam int          stat_expose_bit  = 0;
  localparam int          stat_readout_bit = 1;
  localparam int          stat_running_bit = 2;
  localparam logic [1:0]  source_rst       = 2'h0;
  localparam logic        polarity_rst     = 1'b0;
  localparam logic [15:0] frames_rst       = 16'h0001;
  localparam logic [31:0] exposure_rst     = 32'h0000_0064;
  localparam logic [31:0] interval_rst     = 32'h0000_03E8;
  localparam logic [31:0] readout_rst      = 32'h0000_0032;
  localparam logic [15:0] frames_one       = 16'h0001;
  localparam logic [31:0] count_one        = 32'h0000_0001;

  typedef enum logic [1:0] {
    src_none,
    src_standard,
    src_pulse_width,
    src_reserved
  } trigger_source_select_t;

  typedef enum {
    st_idle,
    st_expose,
    st_readout,
    st_wait
  } seq_state_t;

  typedef struct packed {
    trigger_source_select_t trigger_source_select;
    logic                   trigger_polarity_select;
    logic [15:0]            frames;
    logic [31:0]            exposure_cycles;
    logic [31:0]            interval_cycles;
    logic [31:0]            readout_cycles;
  } seq_cfg_t;

endpackage : exposure_trigger_pkg

// >>> rtl/exposure_trigger_sequencer.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns

module exposure_trigger_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_in,
  output logic             exposure_active,
  output logic             readout_active
);
  import exposure_trigger_pkg::*;

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  seq_cfg_t    cfg_q, cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic        slverr_q, slverr_d;
  logic        capture_cmd, halt_cmd;
  logic [31:0] frames_done_q, frames_done_d;
  seq_state_t  state_q, state_d;
  logic        running_q, running_d;

  // ---------------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------------
  // The slave never inserts wait states, so each access phase ends at its
  // first edge; read data is loaded while the setup cycle is on the bus.
  logic setup;
  logic wr_acc;

  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  // The error flag is shown only while its access phase is on the bus.
  assign pslverr = slverr_q && psel && penable;

  // ---------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------
  // Unmapped reads return zero with an error; writes there are dropped.
  always_comb
  begin
    cfg_d       = cfg_q;
    prdata_d    = prdata_q;
    slverr_d    = slverr_q;
    capture_cmd = 1'b0;
    halt_cmd    = 1'b0;
    if (setup)
    begin
      prdata_d = 32'h0000_0000;
      slverr_d = 1'b0;
      if (paddr == ctrl_addr)
      begin
        prdata_d[source_lsb +: source_width] = cfg_q.trigger_source_select;
        prdata_d[polarity_bit]               = cfg_q.trigger_polarity_select;
      end
      else if (paddr == frames_addr)
        prdata_d[frames_msb:0] = cfg_q.frames;
      else if (paddr == exposure_addr)
        prdata_d = cfg_q.exposure_cycles;
      else if (paddr == interval_addr)
        prdata_d = cfg_q.interval_cycles;
      else if (paddr == readout_addr)
        prdata_d = cfg_q.readout_cycles;
      else if (paddr == command_addr)
        prdata_d = 32'h0000_0000;
      else if (paddr == status_addr)
      begin
        prdata_d[stat_expose_bit]  = exposure_active;
        prdata_d[stat_readout_bit] = readout_active;
        prdata_d[stat_running_bit] = running_q;
      end
      else if (paddr == done_addr)
        prdata_d = frames_done_q;
      else
        slverr_d = 1'b1;
    end
    if (wr_acc)
    begin
      if (paddr == ctrl_addr)
      begin
        cfg_d.trigger_source_select =
          trigger_source_select_t'(pwdata[source_lsb +: source_width]);
        cfg_d.trigger_polarity_select = pwdata[polarity_bit];
      end
      else if (paddr == frames_addr)
        cfg_d.frames = pwdata[frames_msb:0];
      else if (paddr == exposure_addr)
        cfg_d.exposure_cycles = pwdata;
      else if (paddr == interval_addr)
        cfg_d.interval_cycles = pwdata;
      else if (paddr == readout_addr)
        cfg_d.readout_cycles = pwdata;
      else if (paddr == command_addr)
      begin
        capture_cmd = pwdata[cmd_capture_bit];
        halt_cmd    = pwdata[cmd_halt_bit];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q.trigger_source_select   <= trigger_source_select_t'(source_rst);
      cfg_q.trigger_polarity_select <= polarity_rst;
      cfg_q.frames                  <= frames_rst;
      cfg_q.exposure_cycles         <= exposure_rst;
      cfg_q.interval_cycles         <= interval_rst;
      cfg_q.readout_cycles          <= readout_rst;
      prdata_q                      <= 32'h0000_0000;
      slverr_q                      <= 1'b0;
    end
    else
    begin
      cfg_q    <= cfg_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // ---------------------------------------------------------------------
  // Trigger synchroniser and edge detection
  // ---------------------------------------------------------------------
  logic sync1_q, sync2_q, sync3_q;
  logic trig_level, trig_prev, trig_event;

  // Only the second stage reads the first; the third stage just keeps the
  // previous synchronised level for the edge detector. All stages reset to
  // the idle level of a low-polarity trigger, so no false edge follows reset.
  // two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
    end
    else
    begin
      sync1_q <= trigger_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Polarity inverts both samples alike, so changing it never makes an
  // edge by itself.
  // polarity selects edge
  assign trig_level = cfg_q.trigger_polarity_select ? sync2_q : !sync2_q;
  assign trig_prev  = cfg_q.trigger_polarity_select ? sync3_q : !sync3_q;
  assign trig_event = trig_level && !trig_prev;

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  logic [31:0] timer_q, timer_d;
  logic [31:0] period_q, period_d;
  logic [15:0] left_q, left_d;
  logic        streaming;
  logic        timer_done;
  logic        period_done;
  logic        exposure_q, exposure_d;
  logic        readout_q, readout_d;

  // A frame count of zero streams as well as any count above one.
  // mode from frame count
  assign streaming   = cfg_q.frames != frames_one;
  assign timer_done  = timer_q <= count_one;
  assign period_done = period_q <= count_one;

  // Both counters run down every cycle and park at zero; a state reloads
  // only the counter that it needs, so a zero count still lasts one cycle.
  // only these settings steer sequencing
  always_comb
  begin
    state_d       = state_q;
    timer_d       = (timer_q != 32'h0000_0000) ? timer_q - count_one : timer_q;
    period_d      = (period_q != 32'h0000_0000) ? period_q - count_one
                                                 : period_q;
    left_d        = left_q;
    running_d     = running_q;
    frames_done_d = frames_done_q;
    case (state_q)
      st_idle:
      begin
        running_d = 1'b0;
        if (cfg_q.trigger_source_select == src_none && capture_cmd)
        begin
          state_d   = st_expose;
          timer_d   = cfg_q.exposure_cycles;
          period_d  = cfg_q.interval_cycles;
          left_d    = cfg_q.frames;
          running_d = 1'b1;
        end
        else if (cfg_q.trigger_source_select == src_standard && trig_event)
        begin
          state_d   = st_expose;
          timer_d   = cfg_q.exposure_cycles;
          period_d  = cfg_q.interval_cycles;
          running_d = streaming;
        end
        else if (cfg_q.trigger_source_select == src_pulse_width &&
                 trig_event)
          state_d = st_expose;
      end
      st_expose:
      begin
        if (cfg_q.trigger_source_select == src_pulse_width)
        begin
          if (!trig_level)
          begin
            state_d = st_readout;
            timer_d = cfg_q.readout_cycles;
          end
        end
        else if (timer_done)
        begin
          state_d = st_readout;
          timer_d = cfg_q.readout_cycles;
        end
      end
      st_readout:
      begin
        if (timer_done)
        begin
          frames_done_d = frames_done_q + count_one;
          if (cfg_q.trigger_source_select == src_none &&
              left_q > frames_one)
          begin
            left_d  = left_q - frames_one;
            state_d = st_wait;
          end
          // A frame count of zero captures until software halts.
          else if (cfg_q.trigger_source_select == src_none &&
                   left_q == 16'h0000)
            state_d = st_wait;
          else if (running_q && cfg_q.trigger_source_select == src_standard)
            state_d = st_wait;
          else
            state_d = st_idle;
        end
      end
      st_wait:
      begin
        if (period_done)
        begin
          state_d  = st_expose;
          timer_d  = cfg_q.exposure_cycles;
          period_d = cfg_q.interval_cycles;
        end
      end
      default:
        state_d = st_idle;
    endcase
    // Halt wins over every transition chosen above.
    // a halt or a change of source to src_pulse_width ends standard streaming; a counted capture stops at its frame count
    if (halt_cmd)
    begin
      state_d   = st_idle;
      running_d = 1'b0;
    end
    exposure_d = state_d == st_expose;
    readout_d  = state_d == st_readout;
  end

  // ---------------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------------
  // The indicators are registered so the external strobe cannot glitch
  // while the state register changes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q       <= st_idle;
      timer_q       <= 32'h0000_0000;
      period_q      <= 32'h0000_0000;
      left_q        <= 16'h0000;
      running_q     <= 1'b0;
      frames_done_q <= 32'h0000_0000;
      exposure_q    <= 1'b0;
      readout_q     <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      timer_q       <= timer_d;
      period_q      <= period_d;
      left_q        <= left_d;
      running_q     <= running_d;
      frames_done_q <= frames_done_d;
      exposure_q    <= exposure_d;
      readout_q     <= readout_d;
    end
  end

  // ---------------------------------------------------------------------
  // Indicator outputs
  // ---------------------------------------------------------------------
  // indicator only during exposure
  assign exposure_active = exposure_q;
  assign readout_active  = readout_q;

endmodule : exposure_trigger_sequencer

// >>> dv/trigger_source_model.sv
`timescale 1ns/1ns
module trigger_source_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pol,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  output logic            trigger_in
);
  logic [7:0] cnt_q, cnt_d;
  always_comb
  begin
    cnt_d = cnt_q;
    if (fire)
      cnt_d = width;
    else if (cnt_q != 8'h00)
      cnt_d = cnt_q - 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  assign trigger_in = (cnt_q != 8'h00) ? pol : !pol;
endmodule : trigger_source_model

// >>> dv/exposure_trigger_sequencer_asserts.sv
`timescale 1ns/1ns
module exposure_trigger_sequencer_asserts
  import exposure_trigger_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        trigger_in,
  input wire logic        exposure_active,
  input wire logic        readout_active
);
  logic [1:0] src_q, src_d;
  logic       pol_q, pol_d, one_q, one_d, wr, halt_wr;
  assign wr = psel && penable && pwrite;
  assign halt_wr = wr && paddr == command_addr && pwdata[cmd_halt_bit];
  always_comb
  begin
    src_d = src_q;
    pol_d = pol_q;
    one_d = one_q;
    if (wr && paddr == ctrl_addr)
    begin
      src_d = pwdata[1:0];
      pol_d = pwdata[polarity_bit];
    end
    if (wr && paddr == frames_addr)
      one_d = pwdata[15:0] == frames_one;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      src_q <= source_rst;
      pol_q <= polarity_rst;
      one_q <= 1'b1;
    end
    else
    begin
      src_q <= src_d;
      pol_q <= pol_d;
      one_q <= one_d;
    end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stat;
    psel && !penable && !pwrite && paddr == status_addr;
  endsequence
  sequence s_end;
    $fell(exposure_active) && !$past(halt_wr);
  endsequence
  property p_rst_idle;
    $rose(presetn) |-> !exposure_active && !readout_active;
  endproperty
  property p_excl;
    !(exposure_active && readout_active);
  endproperty
  property p_follow;
    s_end |-> readout_active;
  endproperty
  property p_rd_after;
    $rose(readout_active) |-> $past(exposure_active);
  endproperty
  property p_status;
    s_stat ##1 penable |->
      prdata[1:0] == {$past(readout_active), $past(exposure_active)};
  endproperty
  property p_bulb_end;
    src_q == src_pulse_width ##0 s_end |-> $past(trigger_in, 3) != pol_q;
  endproperty
  property p_bulb_start;
    src_q == src_pulse_width && $rose(exposure_active) |->
      $past(trigger_in, 3) == pol_q;
  endproperty
  property p_async_start;
    src_q == src_standard && one_q && $rose(exposure_active) |->
      $past(trigger_in, 3) == pol_q;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  a_excl: assert property (p_excl) else $error("expose in readout");
  a_follow: assert property (p_follow) else $error("no readout");
  a_rd_after: assert property (p_rd_after) else $error("lone readout");
  a_status: assert property (p_status) else $error("status bits");
  a_bulb_end: assert property (p_bulb_end) else $error("bulb end");
  a_bulb_start: assert property (p_bulb_start) else $error("bulb start");
  a_async_start: assert property (p_async_start) else $error("no trigger");
endmodule : exposure_trigger_sequencer_asserts

bind exposure_trigger_sequencer exposure_trigger_sequencer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .trigger_in(trigger_in), .exposure_active(exposure_active),
  .readout_active(readout_active));

// >>> dv/tb_camera_exposure_trigger_sequencer.sv
`timescale 1ns/1ns
module tb_camera_exposure_trigger_sequencer;
  import exposure_trigger_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, fire, pol, e;
  logic        pready, pslverr, trigger_in, exposure_active, readout_active;
  logic [7:0]  paddr, width, w;
  logic [15:0] seed, fr [2] = '{16'h0000, 16'h0003};
  logic [31:0] pwdata, prdata, q, en, ro, iv, dn;
  int          failures, n_compared, cyc, t0, ex, rd, st;
  exposure_trigger_sequencer dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trigger_in), .exposure_active(exposure_active),
    .readout_active(readout_active));
  trigger_source_model u_trig (.pclk(pclk), .presetn(presetn), .pol(pol),
    .fire(fire), .width(width), .trigger_in(trigger_in));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctrl_word(input logic [1:0] s,
                                             input logic p);
    return {29'h0, p, s};
  endfunction : ctrl_word
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic apb(input logic wn, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wn;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic [7:0] pw);
    @(posedge pclk);
    width <= pw;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : pulse
  task automatic frame(input int lim);
    ex = 0;
    rd = 0;
    repeat (lim)
    begin
      @(negedge pclk);
      if (exposure_active === 1'b1)
        break;
    end
    st = cyc;
    while (exposure_active === 1'b1)
    begin
      ex++;
      @(negedge pclk);
    end
    while (readout_active === 1'b1)
    begin
      rd++;
      @(negedge pclk);
    end
  endtask : frame
  task automatic cfg(input logic [1:0] s, input logic p,
                     input logic [15:0] f);
    apb(1'b1, frames_addr, {16'h0000, f});
    apb(1'b1, exposure_addr, en);
    apb(1'b1, readout_addr, ro);
    apb(1'b1, interval_addr, iv);
    apb(1'b1, ctrl_addr, ctrl_word(s, p));
    pol <= p;
  endtask : cfg
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("Error %0t watchdog expired", $time);
    end_sim;
  end
  initial
  begin
    {psel, penable, pwrite, fire, pol, presetn} = 6'h00;
    {paddr, width, pwdata} = '0;
    seed = 16'h2B7C;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, frames_addr, 32'h0);
    chk(q === {16'h0, frames_rst} && e === 1'b0, "frames reset");
    apb(1'b0, exposure_addr, 32'h0);
    chk(q === exposure_rst, "exposure reset");
    apb(1'b0, 8'h20, 32'h0);
    chk(e === 1'b1 && q === 32'h0, "unmapped read");
    seed = lfsr(seed);
    en = 32'h3 + seed[3:0];
    ro = 32'h10 + seed[7:4];
    iv = en + ro + 32'hA + seed[11:8];
    w = 8'h0A + seed[15:12];
    cfg(src_standard, 1'b0, frames_one);
    pulse(8'h08);
    frame(20);
    chk(ex == en && rd == ro, "async frame");
    frame(30);
    chk(ex == 0, "trigger seen twice");
    pulse(8'h08);
    wait (readout_active === 1'b1);
    pulse(8'h06);
    wait (readout_active === 1'b0);
    frame(30);
    chk(ex == 0, "trigger in readout kept");
    cfg(src_standard, 1'b1, frames_one);
    pulse(8'h08);
    frame(20);
    chk(ex == en && rd == ro, "rising edge frame");
    apb(1'b1, readout_addr, ro + 32'h8);
    pulse(8'h08);
    frame(20);
    chk(ex == en && rd == ro + 32'h8, "readout setting");
    cfg(src_pulse_width, 1'b0, frames_one);
    pulse(w);
    frame(20);
    chk(ex >= w - 1 && ex <= w + 1 && rd == ro, "bulb length");
    foreach (fr[i])
    begin
      cfg(src_standard, 1'b0, fr[i]);
      pulse(8'h08);
      frame(20);
      t0 = st;
      pulse(8'h08);
      frame(iv);
      chk(st - t0 == iv && ex == en, "repeat interval");
      apb(1'b1, command_addr, 32'h2);
      frame(iv);
      chk(ex == 0, "halted");
    end
    cfg(src_none, 1'b0, 16'h0002);
    apb(1'b0, done_addr, 32'h0);
    dn = q;
    pulse(8'h08);
    frame(30);
    chk(ex == 0, "trigger not ignored");
    apb(1'b1, command_addr, 32'h1);
    frame(20);
    chk(ex == en && rd == ro, "capture frame");
    frame(iv);
    chk(ex == en, "second capture frame");
    frame(iv);
    chk(ex == 0, "frame count exceeded");
    apb(1'b0, done_addr, 32'h0);
    chk(q === dn + 32'h2, "frames counted");
    cfg(src_standard, 1'b0, frames_one);
    pulse(8'h08);
    wait (exposure_active === 1'b1);
    apb(1'b0, status_addr, 32'h0);
    chk(q[0] === 1'b1, "status exposing");
    presetn <= 1'b0;
    @(negedge pclk);
    chk(!exposure_active && !readout_active, "reset idle");
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    chk(!exposure_active && !readout_active, "idle after release");
    apb(1'b0, ctrl_addr, 32'h0);
    chk(q === ctrl_word(source_rst, polarity_rst), "ctrl reset");
    end_sim;
  end
endmodule : tb_camera_exposure_trigger_sequencer
